// *** hdl/pss_sequencer.sv ***
// Purpose: Sequences entry to and exit from clock-stopped and powered-down states
// Assumes: Core gives a sleep request pulse; all inputs but external_reset_pin synchronous to clk
// Notes: APB slave answers one cycle after setup; outputs are registered
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module pss_sequencer (
  input wire logic clk,
  input wire logic external_reset_pin,
  input wire logic [pss_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic coreDeepRequest,
  input wire logic sleepReq,
  input wire logic sleepByEvent,
  output logic resumePulse,
  output logic entryIgnored,
  input wire logic flashBusy,
  input wire logic periphBusBusy,
  input wire logic pendingAny,
  input wire logic extLineIrqWake,
  input wire logic periphIrqWake,
  input wire logic extLineEventWake,
  input wire logic [pss_pkg::WAKE_PINS-1:0] wakePin,
  input wire logic externalResetPinN,
  input wire logic watchdogReset,
  input wire logic calendarEvent,
  input wire logic watchdogStarted,
  output logic coreClkEn,
  output logic pllEn,
  output logic fastRcEn,
  output logic fastExtOscEn,
  output logic sysClkFastRc,
  output logic regLowPower,
  output logic regOff,
  output logic coreDomainPowerEn,
  output logic ioHold,
  output logic ioHighZ,
  output logic [pss_pkg::WAKE_PINS-1:0] wakePinKeep,
  output logic calendarPinKeep,
  output logic independentWatchdogRun,
  output logic calendarClockRun,
  output logic slowInternalRcRun,
  output logic slowExternalOscRun,
  output logic restartPulse
);
  import pss_pkg::*;

  typedef struct packed {
    pss_mode_e mode;
    logic byEvent;
    logic lowPowerLatched;
    logic regulatorLowpowerSelect;
    logic powerdownDeepsleepSelect;
    logic standbyEnteredFlag;
    logic [WAKE_PINS-1:0] wakeEn;
    logic calendarClockEnable;
    logic slowInternalRcOn;
    logic slowExternalOscOn;
    logic wdgRunning;
    logic [WAKE_PINS-1:0] wakePinPrev;
    logic tmrStart;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic resume;
    logic ignored;
    logic coreClk;
    logic pll;
    logic fastRc;
    logic fastExt;
    logic sysRc;
    logic regLp;
    logic regDown;
    logic domainPwr;
    logic hold;
    logic highZ;
    logic calPin;
    logic restart;
  } pss_state_s;

  pss_state_s cur, nxt;
  logic [1:0] rstSync;
  logic rstN;
  pss_timer_if tmrBus ();

  // ==========================================================
  // Reset release
  always_ff @(posedge clk or negedge external_reset_pin) begin
    if (!external_reset_pin) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // ==========================================================
  // Wake timer
  pss_wake_timer u_pss_wake_timer (
    .clk(clk),
    .rstN(rstN),
    .tmr(tmrBus.tmr)
  );
  assign tmrBus.start = cur.tmrStart;
  assign tmrBus.lowPower = cur.lowPowerLatched;

  // ==========================================================
  // Decoding
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == ADDR_CTRL) || (a == ADDR_STAT) || (a == ADDR_KEEP);
  endfunction

  function automatic logic [31:0] readWord(input pss_state_s s, input logic [ADDR_W-1:0] a);
    logic [31:0] w;
    w = 32'h0;
    case (a)
      ADDR_CTRL: begin
        w[CTRL_REGLP_BIT] = s.regulatorLowpowerSelect;
        w[CTRL_PWRDN_BIT] = s.powerdownDeepsleepSelect;
      end
      ADDR_STAT: begin
        w[STAT_STBYFLAG_BIT] = s.standbyEnteredFlag;
        w[STAT_WAKEEN_LSB +: WAKE_PINS] = s.wakeEn;
      end
      ADDR_KEEP: begin
        w[KEEP_CAL_BIT] = s.calendarClockEnable;
        w[KEEP_SRC_BIT] = s.slowInternalRcOn;
        w[KEEP_SXO_BIT] = s.slowExternalOscOn;
        w[KEEP_WDG_BIT] = s.wdgRunning;
        w[KEEP_MODE_LSB +: 3] = s.mode;
      end
      default: begin
        w = 32'h0;
      end
    endcase
    readWord = w;
  endfunction

  // ==========================================================
  // Next state
  logic wrTake;
  logic standbyWake;
  logic stopWake;
  logic busBusy;

  always_comb begin
    nxt = cur;
    wrTake = psel && penable && pwrite && cur.ready;
    busBusy = periphBusBusy || psel;
    stopWake = cur.byEvent ? extLineEventWake
                           : (extLineIrqWake || periphIrqWake);
    standbyWake = !externalResetPinN || watchdogReset || calendarEvent
                  || |(wakePin & ~cur.wakePinPrev & cur.wakeEn);
    nxt.wakePinPrev = wakePin;
    nxt.tmrStart = 1'b0;
    nxt.resume = 1'b0;
    nxt.ignored = 1'b0;
    nxt.restart = 1'b0;
    nxt.sysRc = 1'b0;

    // APB slave: answer in the access phase
    nxt.ready = psel && !penable;
    nxt.slverr = psel && !penable && !isMapped(paddr);
    nxt.rdata = (psel && !penable && !pwrite) ? readWord(cur, paddr) : 32'h0;
    if (wrTake) begin
      case (paddr)
        ADDR_CTRL: begin
          nxt.regulatorLowpowerSelect = pwdata[CTRL_REGLP_BIT];
          nxt.powerdownDeepsleepSelect = pwdata[CTRL_PWRDN_BIT];
          if (pwdata[CTRL_CLRSB_BIT]) begin
            nxt.standbyEnteredFlag = 1'b0;
          end
        end
        ADDR_STAT: begin
          nxt.wakeEn = pwdata[STAT_WAKEEN_LSB +: WAKE_PINS];
        end
        ADDR_KEEP: begin
          nxt.calendarClockEnable = pwdata[KEEP_CAL_BIT];
          nxt.slowInternalRcOn = pwdata[KEEP_SRC_BIT];
          nxt.slowExternalOscOn = pwdata[KEEP_SXO_BIT];
        end
        default: begin
          nxt.wakeEn = cur.wakeEn;
        end
      endcase
    end

    // Watchdog: once started only reset stops it
    if (watchdogStarted) begin
      nxt.wdgRunning = 1'b1;
    end

    case (cur.mode)
      PSS_RUN: begin
        if (sleepReq && coreDeepRequest) begin
          nxt.byEvent = sleepByEvent;
          if (pendingAny) begin
            nxt.ignored = 1'b1;
          end else if (flashBusy || busBusy) begin
            nxt.mode = PSS_HOLD;
          end else if (cur.powerdownDeepsleepSelect) begin
            nxt.mode = PSS_STBY;
            nxt.standbyEnteredFlag = 1'b1;
          end else begin
            nxt.mode = PSS_STOP;
            nxt.lowPowerLatched = cur.regulatorLowpowerSelect;
          end
        end
      end
      PSS_HOLD: begin
        if (!flashBusy && !busBusy) begin
          if (cur.powerdownDeepsleepSelect) begin
            nxt.mode = PSS_STBY;
            nxt.standbyEnteredFlag = 1'b1;
          end else begin
            nxt.mode = PSS_STOP;
            nxt.lowPowerLatched = cur.regulatorLowpowerSelect;
          end
        end
      end
      PSS_STOP: begin
        if (stopWake) begin
          nxt.mode = PSS_RESUME;
          nxt.tmrStart = 1'b1;
        end
      end
      PSS_RESUME: begin
        if (tmrBus.done) begin
          nxt.mode = PSS_RUN;
          nxt.resume = 1'b1;
          nxt.sysRc = 1'b1;
        end
      end
      PSS_STBY: begin
        if (standbyWake) begin
          nxt.mode = PSS_RESTART;
        end
      end
      PSS_RESTART: begin
        nxt.mode = PSS_RUN;
        nxt.restart = 1'b1;
        nxt.regulatorLowpowerSelect = CTRL_BIT_RST;
        nxt.powerdownDeepsleepSelect = CTRL_BIT_RST;
        nxt.calendarClockEnable = KEEP_RST[KEEP_CAL_BIT];
        nxt.slowInternalRcOn = KEEP_RST[KEEP_SRC_BIT];
        nxt.slowExternalOscOn = KEEP_RST[KEEP_SXO_BIT];
      end
      default: begin
        nxt.mode = PSS_RUN;
      end
    endcase

    // Registered outputs follow the next mode
    nxt.coreClk = (nxt.mode == PSS_RUN) || (nxt.mode == PSS_HOLD)
                  || (nxt.mode == PSS_RESTART);
    nxt.pll = nxt.coreClk;
    nxt.fastExt = nxt.coreClk;
    nxt.fastRc = nxt.coreClk || (nxt.mode == PSS_RESUME);
    nxt.regLp = (nxt.mode == PSS_STOP) && nxt.lowPowerLatched;
    nxt.regDown = (nxt.mode == PSS_STBY);
    nxt.domainPwr = (nxt.mode != PSS_STBY);
    nxt.hold = (nxt.mode == PSS_STOP) || (nxt.mode == PSS_RESUME);
    nxt.highZ = (nxt.mode == PSS_STBY);
    nxt.calPin = (nxt.mode == PSS_STBY)
                 && (nxt.calendarClockEnable || nxt.slowExternalOscOn);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cur <= '0;
      cur.mode <= PSS_RUN;
      cur.regulatorLowpowerSelect <= CTRL_BIT_RST;
      cur.powerdownDeepsleepSelect <= CTRL_BIT_RST;
      cur.wakeEn <= WAKEEN_RST;
      cur.calendarClockEnable <= KEEP_RST[KEEP_CAL_BIT];
      cur.slowInternalRcOn <= KEEP_RST[KEEP_SRC_BIT];
      cur.slowExternalOscOn <= KEEP_RST[KEEP_SXO_BIT];
      cur.coreClk <= 1'b1;
      cur.pll <= 1'b1;
      cur.fastRc <= 1'b1;
      cur.fastExt <= 1'b1;
      cur.domainPwr <= 1'b1;
    end else begin
      cur <= nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = cur.rdata;
  assign pready = cur.ready;
  assign pslverr = cur.slverr;
  assign resumePulse = cur.resume;
  assign entryIgnored = cur.ignored;
  assign coreClkEn = cur.coreClk;
  assign pllEn = cur.pll;
  assign fastRcEn = cur.fastRc;
  assign fastExtOscEn = cur.fastExt;
  assign sysClkFastRc = cur.sysRc;
  assign regLowPower = cur.regLp;
  assign regOff = cur.regDown;
  assign coreDomainPowerEn = cur.domainPwr;
  assign ioHold = cur.hold;
  assign ioHighZ = cur.highZ;
  assign wakePinKeep = cur.wakeEn;
  assign calendarPinKeep = cur.calPin;
  assign independentWatchdogRun = cur.wdgRunning;
  assign calendarClockRun = cur.calendarClockEnable;
  assign slowInternalRcRun = cur.slowInternalRcOn;
  assign slowExternalOscRun = cur.slowExternalOscOn;
  assign restartPulse = cur.restart;
endmodule

// *** shared/pss_pkg.sv ***
// Purpose: Shared constants and types of the stop/standby power sequencer
// Assumes: 40 MHz system clock, APB register access, 32-bit data
// Notes: Register offsets are byte addresses
package pss_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ = 40;
  localparam int FAST_RC_START_NS = 2000;
  localparam int REG_RECOVER_NS = 5000;
  localparam int FAST_RC_START_CYC = (FAST_RC_START_NS * CLK_MHZ + 999) / 1000;
  localparam int REG_RECOVER_CYC = (REG_RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 10;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_KEEP = 8'h08;
  localparam int CTRL_REGLP_BIT = 0;
  localparam int CTRL_PWRDN_BIT = 1;
  localparam int CTRL_CLRSB_BIT = 3;
  localparam int STAT_STBYFLAG_BIT = 1;
  localparam int STAT_WAKEEN_LSB = 8;
  localparam int KEEP_CAL_BIT = 0;
  localparam int KEEP_SRC_BIT = 1;
  localparam int KEEP_SXO_BIT = 2;
  localparam int KEEP_WDG_BIT = 3;
  localparam int KEEP_MODE_LSB = 4;
  localparam int WAKE_PINS = 8;
  localparam logic CTRL_BIT_RST = 1'b0;
  localparam logic [7:0] WAKEEN_RST = 8'h00;
  localparam logic [2:0] KEEP_RST = 3'h0;

  // ==========================================================
  // Sequencer modes
  typedef enum logic [2:0] {
    PSS_RUN,
    PSS_HOLD,
    PSS_STOP,
    PSS_RESUME,
    PSS_STBY,
    PSS_RESTART
  } pss_mode_e;
endpackage

// *** shared/pss_timer_if.sv ***
// Purpose: Carries wake-delay requests between sequencer and timer
// Assumes: Single clock domain
// Notes: start and done are one-cycle pulses
`timescale 1ns/1ps
interface pss_timer_if;
  logic start;
  logic lowPower;
  logic done;
  modport seq (output start, output lowPower, input done);
  modport tmr (input start, input lowPower, output done);
endinterface

// *** hdl/pss_wake_timer.sv ***
// Purpose: Counts wake-up latency out of the clock-stopped state
// Assumes: start pulse only while idle
// Notes: Latency is RC start time, plus regulator recovery when low power
`timescale 1ns/1ps
module pss_wake_timer (
  input wire logic clk,
  input wire logic rstN,
  pss_timer_if.tmr tmr
);
  import pss_pkg::*;

  typedef struct packed {
    logic busy;
    logic [TMR_W-1:0] count;
    logic done;
  } pss_tmr_s;

  pss_tmr_s cur, nxt;

  // ==========================================================
  // Countdown
  always_comb begin
    nxt = cur;
    nxt.done = 1'b0;
    if (tmr.start && !cur.busy) begin
      nxt.busy = 1'b1;
      if (tmr.lowPower) begin
        nxt.count = TMR_W'(FAST_RC_START_CYC + REG_RECOVER_CYC - 1);
      end else begin
        nxt.count = TMR_W'(FAST_RC_START_CYC - 1);
      end
    end else if (cur.busy) begin
      if (cur.count == '0) begin
        nxt.busy = 1'b0;
        nxt.done = 1'b1;
      end else begin
        nxt.count = cur.count - TMR_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign tmr.done = cur.done;
endmodule

// *** sim/pss_core_model.sv ***
// Purpose: Core and event controller model facing the power sequencer
// Assumes: Requests from the bench arrive as one-cycle strobes
// Notes: A wake source stays raised until the core runs again
`timescale 1ns/1ps
module pss_core_model (
  input wire logic clk,
  input wire logic rstN,
  input wire logic fire,
  input wire logic byEvent,
  input wire logic deep,
  input wire logic wake,
  input wire logic [1:0] kind,
  input wire logic resumePulse,
  output logic sleepReq,
  output logic sleepByEvent,
  output logic coreDeepRequest,
  output logic extLineIrqWake,
  output logic periphIrqWake,
  output logic extLineEventWake
);
  // ==========================================================
  // Halt instruction and wake lines
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      {sleepReq, sleepByEvent, coreDeepRequest} <= 3'h0;
      {extLineIrqWake, periphIrqWake, extLineEventWake} <= 3'h0;
    end else begin
      // Deep bit and halt request are registered from the bench in the same cycle
      coreDeepRequest <= deep;
      sleepReq <= fire;
      sleepByEvent <= byEvent;
      if (wake) begin
        extLineIrqWake <= kind == 2'h0;
        periphIrqWake <= kind == 2'h1;
        extLineEventWake <= kind == 2'h2;
      end else if (resumePulse) begin
        {extLineIrqWake, periphIrqWake, extLineEventWake} <= 3'h0;
      end
    end
  end
endmodule

// *** sim/pss_sequencer_asserts.sv ***
// Purpose: Temporal checks on the power sequencer ports
// Assumes: One clock domain, external_reset_pin active low
// Notes: Wake latency is judged by a helper counter
`timescale 1ns/1ps
module pss_sequencer_asserts (
  input wire logic clk,
  input wire logic external_reset_pin,
  input wire logic sleepReq,
  input wire logic coreDeepRequest,
  input wire logic pendingAny,
  input wire logic flashBusy,
  input wire logic periphBusBusy,
  input wire logic psel,
  input wire logic calendarEvent,
  input logic resumePulse,
  input logic entryIgnored,
  input logic coreClkEn,
  input logic pllEn,
  input logic fastRcEn,
  input logic fastExtOscEn,
  input logic sysClkFastRc,
  input logic regLowPower,
  input logic regOff,
  input logic coreDomainPowerEn,
  input logic ioHold,
  input logic ioHighZ,
  input logic calendarPinKeep,
  input logic independentWatchdogRun,
  input logic restartPulse
);
  import pss_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!external_reset_pin);
  int waitCnt_ff;
  logic lpSeen_ff;
  int base;
  assign base = lpSeen_ff ? FAST_RC_START_CYC + REG_RECOVER_CYC : FAST_RC_START_CYC;
  always_ff @(posedge clk or negedge external_reset_pin) begin
    if (!external_reset_pin) begin
      waitCnt_ff <= 0;
      lpSeen_ff <= 1'b0;
    end else begin
      waitCnt_ff <= (ioHold && fastRcEn) ? waitCnt_ff + 1 : 0;
      lpSeen_ff <= regLowPower || (lpSeen_ff && !resumePulse);
    end
  end
  // ==========================================================
  // Assertions
  a_ignore_cause: assert property (entryIgnored |-> $past(sleepReq) && $past(pendingAny))
    else $error("entry refusal without pending request");
  a_stop_clocks: assert property ($rose(ioHold) |-> !coreClkEn && !pllEn && !fastRcEn
    && !fastExtOscEn && coreDomainPowerEn) else $error("clocks still on in stop");
  a_entry_idle: assert property ($rose(ioHold) |-> !$past(flashBusy)
    && !$past(periphBusBusy) && !$past(psel)) else $error("stop entered while busy");
  a_reg_low: assert property (regLowPower |-> ioHold && !coreClkEn)
    else $error("regulator low power outside stop");
  a_resume_rc: assert property (resumePulse |-> sysClkFastRc && coreClkEn && !ioHold)
    else $error("resume without fast rc selected");
  a_wake_time: assert property (resumePulse |-> waitCnt_ff >= base
    && waitCnt_ff <= base + 4) else $error("stop wake latency wrong");
  a_standby_off: assert property ($rose(regOff) |-> ioHighZ && !coreDomainPowerEn
    && !pllEn && !fastRcEn && !fastExtOscEn && !coreClkEn) else $error("standby left power on");
  a_pin_keep: assert property (calendarPinKeep |-> ioHighZ)
    else $error("calendar pin kept outside standby");
  a_wdg_sticky: assert property (!$fell(independentWatchdogRun))
    else $error("watchdog stopped without reset");
  a_standby_exit: assert property (regOff && calendarEvent |-> ##[1:3] restartPulse)
    else $error("no restart after calendar event");
  a_restart_run: assert property (restartPulse |-> coreClkEn && coreDomainPowerEn
    && !ioHighZ) else $error("restart with domain still off");
  a_deep_needed: assert property (sleepReq && !coreDeepRequest && !ioHold && !regOff
    && !flashBusy && !periphBusBusy |=> !ioHold && !regOff) else $error("entry without deep bit");
  c_resume: cover property (resumePulse);
  c_restart: cover property (restartPulse);
  c_ignored: cover property (entryIgnored);
endmodule
bind pss_sequencer pss_sequencer_asserts u_pss_sequencer_asserts (.clk, .external_reset_pin, .sleepReq,
  .coreDeepRequest, .pendingAny, .flashBusy, .periphBusBusy, .psel, .calendarEvent, .resumePulse,
  .entryIgnored, .coreClkEn, .pllEn, .fastRcEn, .fastExtOscEn, .sysClkFastRc, .regLowPower,
  .regOff, .coreDomainPowerEn, .ioHold, .ioHighZ, .calendarPinKeep, .independentWatchdogRun,
  .restartPulse);

// *** sim/stop_standby_power_sequencer_tb_top.sv ***
// Purpose: Self-checking bench for the stop/standby power sequencer
// Assumes: APB slave with zero wait states, core model as far side
// Notes: Register cases run from a table, sleep flows are hand-written
`timescale 1ns/1ps
module stop_standby_power_sequencer_tb_top;
  import pss_pkg::*;
  typedef struct packed {
    logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e; logic [2:0] k;
  } pss_row_s;
  logic clk = 0, external_reset_pin = 0, psel = 0, penable = 0, pwrite = 0, fire = 0, byEv = 0, deep = 1;
  logic wake = 0, flashBusy = 0, periphBusBusy = 0, pendingAny = 0, externalResetPinN = 1;
  logic watchdogReset = 0, calendarEvent = 0, watchdogStarted = 0, er, pready, pslverr;
  logic [1:0] kind = 0;
  logic [7:0] paddr = 0, wakePin = 0, wakePinKeep;
  logic [31:0] pwdata = 0, prdata, rd;
  logic sleepReq, sleepByEvent, coreDeepRequest, resumePulse, entryIgnored, extLineIrqWake;
  logic periphIrqWake, extLineEventWake, coreClkEn, pllEn, fastRcEn, fastExtOscEn, sysClkFastRc;
  logic regLowPower, regOff, coreDomainPowerEn, ioHold, ioHighZ, calendarPinKeep, restartPulse;
  logic independentWatchdogRun, calendarClockRun, slowInternalRcRun, slowExternalOscRun;
  int bad_count = 0, checks_done = 0, n, base;
  pss_row_s rows [7] = '{{ADDR_CTRL, 32'hffffffff, 32'h3, 1'b0, 3'h0},
    {ADDR_CTRL, 32'h0, 32'h0, 1'b0, 3'h0}, {ADDR_STAT, 32'hffffffff, 32'hff00, 1'b0, 3'h0},
    {ADDR_KEEP, 32'hffffffff, 32'h7, 1'b0, 3'h7}, {ADDR_KEEP, 32'h0, 32'h0, 1'b0, 3'h0},
    {ADDR_STAT, 32'h0, 32'h0, 1'b0, 3'h0}, {8'h0c, 32'hffffffff, 32'h0, 1'b1, 3'h0}};
  always #12.5 clk = ~clk;
  pss_sequencer u_pss_sequencer (.clk, .external_reset_pin, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .coreDeepRequest, .sleepReq, .sleepByEvent, .resumePulse, .entryIgnored,
    .flashBusy, .periphBusBusy, .pendingAny, .extLineIrqWake, .periphIrqWake, .extLineEventWake,
    .wakePin, .externalResetPinN, .watchdogReset, .calendarEvent, .watchdogStarted, .coreClkEn,
    .pllEn, .fastRcEn, .fastExtOscEn, .sysClkFastRc, .regLowPower, .regOff, .coreDomainPowerEn,
    .ioHold, .ioHighZ, .wakePinKeep, .calendarPinKeep, .independentWatchdogRun, .calendarClockRun,
    .slowInternalRcRun, .slowExternalOscRun, .restartPulse);
  pss_core_model u_pss_core_model (.clk, .rstN(external_reset_pin), .fire, .byEvent(byEv), .deep, .wake, .kind,
    .resumePulse, .sleepReq, .sleepByEvent, .coreDeepRequest, .extLineIrqWake, .periphIrqWake,
    .extLineEventWake);
  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic sleep_req(input logic ev);
    @(posedge clk);
    fire <= 1;
    byEv <= ev;
    @(posedge clk);
    fire <= 0;
  endtask
  task automatic wait_for(input logic which);
    n = 0;
    while ((which ? restartPulse : resumePulse) !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) bad_count++;
  endtask
  task automatic wake_up(input int k);
    @(posedge clk);
    wake <= 1;
    kind <= 2'(k);
    @(posedge clk);
    wake <= 0;
    wait_for(0);
  endtask
  task automatic src(input int s);
    @(posedge clk);
    wakePin <= {7'h0, s == 0};
    externalResetPinN <= s != 1;
    watchdogReset <= s == 2;
    calendarEvent <= s == 3;
  endtask
  initial begin
    #2000000;
    bad_count++;
    end_of_test;
  end
  // ==========================================================
  // Main sequence
  initial begin
    tick(8);
    external_reset_pin <= 1;
    tick(3);
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      check(er, rows[i].e);
      apb(0, rows[i].a, 0);
      check({calendarClockRun, slowInternalRcRun, slowExternalOscRun}, rows[i].k);
      check(rd, rows[i].x);
      check(er, rows[i].e);
    end
    @(posedge clk) watchdogStarted <= 1;
    @(posedge clk) watchdogStarted <= 0;
    tick(2);
    check(independentWatchdogRun, 1);
    @(posedge clk) external_reset_pin <= 0;
    tick(2);
    check({coreClkEn, pllEn, fastRcEn, fastExtOscEn, coreDomainPowerEn,
           independentWatchdogRun}, 6'h3e);
    @(posedge clk) external_reset_pin <= 1;
    tick(3);
    @(posedge clk) pendingAny <= 1;
    sleep_req(0);
    tick(2);
    check({entryIgnored, ioHold}, 2'h2);
    @(posedge clk) pendingAny <= 0;
    deep <= 0;
    tick(2);
    sleep_req(0);
    tick(3);
    check({entryIgnored, ioHold, regOff}, 3'h0);
    @(posedge clk) deep <= 1;
    for (int b = 0; b < 2; b++) begin
      @(posedge clk) flashBusy <= b == 0;
      periphBusBusy <= b == 1;
      sleep_req(0);
      tick(20);
      check(ioHold, 0);
      @(posedge clk) flashBusy <= 0;
      periphBusBusy <= 0;
      tick(3);
      check(ioHold, 1);
      wake_up(0);
      check(resumePulse, 1);
    end
    for (int k = 0; k < 3; k++) begin
      apb(1, ADDR_CTRL, {31'h0, k == 2});
      sleep_req(k == 2);
      tick(3);
      check({ioHold, coreClkEn, pllEn, fastRcEn, fastExtOscEn}, 5'h10);
      check(regLowPower, k == 2);
      base = (k == 2) ? FAST_RC_START_CYC + REG_RECOVER_CYC : FAST_RC_START_CYC;
      wake_up(k);
      check(n >= base && n <= base + 8, 1);
      check({sysClkFastRc, coreClkEn, ioHold}, 3'h6);
    end
    @(posedge clk) watchdogStarted <= 1;
    @(posedge clk) watchdogStarted <= 0;
    for (int s = 0; s < 4; s++) begin
      apb(1, ADDR_STAT, 32'h100);
      apb(1, ADDR_KEEP, 32'h1);
      apb(1, ADDR_CTRL, 32'h2);
      sleep_req(0);
      tick(3);
      check({regOff, ioHighZ, coreDomainPowerEn}, 3'h6);
      check({wakePinKeep, calendarPinKeep, independentWatchdogRun}, {8'h01, 2'h3});
      @(posedge clk) wakePin <= 8'h02;
      tick(4);
      check(regOff, 1);
      src(9);
      src(s);
      src(9);
      wait_for(1);
      check(n < 10, 1);
      check({coreClkEn, coreDomainPowerEn, regOff, ioHighZ}, 4'hc);
      apb(0, ADDR_CTRL, 0);
      check(rd, 0);
      apb(0, ADDR_KEEP, 0);
      check(rd, 32'h8);
      apb(0, ADDR_STAT, 0);
      check(rd, 32'h102);
      apb(1, ADDR_CTRL, 32'h8);
      apb(0, ADDR_STAT, 0);
      check(rd, 32'h100);
    end
    end_of_test;
  end
endmodule
